/* core/spg_pkg.sv */
// Synthetic pixel generator constants, types and register map
package spg_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_NS       = 100;
    localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_ROWS      = 10'h2D0;
    localparam logic [9:0]  IDX_COLS      = 10'h2D1;
    localparam logic [9:0]  IDX_PERIOD    = 10'h2D2;
    localparam logic [9:0]  IDX_CHANS     = 10'h2D3;
    localparam logic [9:0]  IDX_DELAY     = 10'h2D4;
    localparam logic [9:0]  IDX_INTEG     = 10'h2D5;
    localparam logic [9:0]  IDX_SAMPLES   = 10'h2D6;
    localparam logic [9:0]  IDX_SELECT    = 10'h2D7;
    localparam logic [9:0]  IDX_MODE      = 10'h2FC;
    localparam logic [9:0]  IDX_STATUS    = 10'h2FD;
    localparam logic [2:0]  MODE_RESET    = 3'h0;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [1:0]  KIND_OFF      = 2'h0;
    localparam logic [1:0]  KIND_VIS      = 2'h1;
    localparam logic [1:0]  KIND_IR       = 2'h2;
    localparam logic [1:0]  KIND_SLOT     = 2'h3;
    localparam int unsigned NOISE_BIT     = 2;
    localparam logic [2:0]  SLOT_MAX      = 3'h6;
    localparam logic [7:0]  LFSR_SEED     = 8'h01;
    localparam logic [7:0]  LFSR_TAPS     = 8'hB8;
    localparam int unsigned ST_BUSY       = 0;
    localparam int unsigned ST_SECOND     = 1;
    localparam int unsigned ST_FRAME_LSB  = 8;

    typedef enum logic [2:0] {
        S_IDLE, S_DELAY, S_BURST, S_GAP, S_INTEG, S_ARMED, S_SLOT
    } spg_state_t;

    typedef struct packed {
        logic [7:0] channel;
        logic [7:0] value;
    } spg_pixel_t;
endpackage

/* core/spg_generator.sv */
// Synthetic pixel generator with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module spg_generator #(
    parameter int unsigned MS_CYC_P = spg_pkg::MS_CYC
) (
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    input  wire logic [11:0]        avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    output logic [31:0]             avs_readdata_o,
    output logic                    avs_waitrequest_o,
    input  wire logic               start_exposure_i,
    input  wire logic               pipe_xfer_i,
    input  wire logic [2:0]         pipe_slot_i,
    output logic                    pixel_valid_o,
    output spg_pkg::spg_pixel_t     pixel_o,
    output logic                    gen_xfer_o,
    output logic [2:0]              gen_slot_o,
    output logic                    busy_o
);
    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] be);
        be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    spg_pkg::spg_state_t state_ff, nxt_state;
    logic [15:0] rows_ff, cols_ff, integ_ff;
    logic [7:0]  period_ff, chans_ff, delay_ff, samples_ff, select_ff;
    logic [2:0]  mode_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  ch_ff, frame_ff, seq_ff, lfsr_ff;
    logic [31:0] burst_ff, div_ff;
    logic [15:0] unit_ff;
    logic        second_ff;
    logic [2:0]  slot_ff;
    logic [2:0]  xfer_sync_ff;
    logic [2:0]  slot_s1_ff, slot_s2_ff, slot_s3_ff;
    logic        xfer_lvl_ff;
    logic [2:0]  slot_lvl_ff;
    logic        valid_ff, xfer_ff, busy_ff;
    spg_pkg::spg_pixel_t pix_ff;
    logic [2:0]  gslot_ff;

    // Bus decode
    wire [9:0]  idx      = avs_address_i[11:2];
    wire        req      = avs_read_i | avs_write_i;
    wire        wr_take  = avs_write_i & ~wait_ff;
    wire        wr_byte  = wr_take & avs_byteenable_i[0];
    wire [15:0] wd16     = avs_writedata_i[15:0];
    wire [1:0]  be16     = avs_byteenable_i[1:0];
    wire        mode_wr  = wr_byte & (idx == spg_pkg::IDX_MODE);

    // Mode decode
    // mode kind decode
    wire [1:0]  kind     = mode_ff[1:0];
    wire        noise    = mode_ff[spg_pkg::NOISE_BIT];

    // Frame geometry and timing decode
    wire [31:0] total    = rows_ff * cols_ff;
    wire        timed100 = (state_ff == spg_pkg::S_BURST) | (state_ff == spg_pkg::S_GAP);
    wire [31:0] div_len  = timed100 ? spg_pkg::TICK_CYC : MS_CYC_P;
    wire        tick     = (div_ff == div_len - 32'h1);
    wire        emitting = ((state_ff == spg_pkg::S_BURST) | (state_ff == spg_pkg::S_SLOT))
                           & (chans_ff != 8'h00);
    wire        last_wd  = (chans_ff == 8'h00) | (ch_ff == chans_ff - 8'h01);
    wire        dly_done = (unit_ff >= {8'h00, delay_ff});
    wire        per_done = (unit_ff >= {8'h00, period_ff});
    wire        int_done = (unit_ff >= integ_ff);
    wire        more_brs = (burst_ff < total);
    wire        frm_last = (frame_ff + 8'h01 >= samples_ff);
    // Timer runs on from burst into gap, so the burst period counts start to start
    wire        burst_end = (state_ff == spg_pkg::S_BURST) & (nxt_state == spg_pkg::S_GAP);
    wire        gap_again = (state_ff == spg_pkg::S_GAP) & (nxt_state == spg_pkg::S_BURST);
    wire        load_tmr  = ((nxt_state != state_ff) & ~burst_end) | gap_again;

    // Slot edge decode
    wire        xfer_fell = xfer_lvl_ff & (xfer_sync_ff[2] == xfer_sync_ff[1]) & ~xfer_sync_ff[2];
    wire [2:0]  trig_slot = slot_lvl_ff + 3'h1;
    wire [2:0]  next_slot = slot_ff + 3'h1;
    wire        trig_ok  = (slot_lvl_ff < spg_pkg::SLOT_MAX) & select_ff[trig_slot];
    wire        chain_ok = (slot_ff < spg_pkg::SLOT_MAX) & select_ff[next_slot];

    // Frame end target depends on run kind
    // samples only in infrared
    spg_pkg::spg_state_t after_frm;
    assign after_frm = (kind == spg_pkg::KIND_VIS) ? spg_pkg::S_IDLE :
                       !frm_last ? spg_pkg::S_DELAY :
                       !second_ff ? spg_pkg::S_INTEG : spg_pkg::S_IDLE;
    wire frame_end = ((state_ff == spg_pkg::S_GAP) & per_done & ~more_brs) |
                     ((state_ff == spg_pkg::S_DELAY) & dly_done & (total == 32'h0));

    // Next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            spg_pkg::S_IDLE: begin
                if (kind == spg_pkg::KIND_SLOT)
                    nxt_state = spg_pkg::S_ARMED;
                else if (start_exposure_i & (kind == spg_pkg::KIND_VIS))
                    nxt_state = spg_pkg::S_DELAY;
                else if (start_exposure_i & (kind == spg_pkg::KIND_IR) & (samples_ff != 8'h00))
                    nxt_state = spg_pkg::S_DELAY;
            end
            spg_pkg::S_DELAY: begin
                if (dly_done)
                    nxt_state = (total == 32'h0) ? after_frm : spg_pkg::S_BURST;
            end
            spg_pkg::S_BURST: begin
                if (last_wd)
                    nxt_state = spg_pkg::S_GAP;
            end
            spg_pkg::S_GAP: begin
                if (per_done)
                    nxt_state = more_brs ? spg_pkg::S_BURST : after_frm;
            end
            spg_pkg::S_INTEG: begin
                if (int_done)
                    nxt_state = spg_pkg::S_DELAY;
            end
            spg_pkg::S_ARMED: begin
                if (kind != spg_pkg::KIND_SLOT)
                    nxt_state = spg_pkg::S_IDLE;
                else if (xfer_fell & trig_ok)
                    nxt_state = spg_pkg::S_SLOT;
            end
            spg_pkg::S_SLOT: begin
                if (last_wd)
                    nxt_state = chain_ok ? spg_pkg::S_SLOT : spg_pkg::S_ARMED;
            end
            default: nxt_state = spg_pkg::S_IDLE;
        endcase
        if (mode_wr)
            nxt_state = spg_pkg::S_IDLE;
    end

    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (avs_read_i & wait_ff) begin
                case (idx)
                    spg_pkg::IDX_ROWS:    rdata_ff <= {16'h0000, rows_ff};
                    spg_pkg::IDX_COLS:    rdata_ff <= {16'h0000, cols_ff};
                    spg_pkg::IDX_PERIOD:  rdata_ff <= {24'h000000, period_ff};
                    spg_pkg::IDX_CHANS:   rdata_ff <= {24'h000000, chans_ff};
                    spg_pkg::IDX_DELAY:   rdata_ff <= {24'h000000, delay_ff};
                    spg_pkg::IDX_INTEG:   rdata_ff <= {16'h0000, integ_ff};
                    spg_pkg::IDX_SAMPLES: rdata_ff <= {24'h000000, samples_ff};
                    spg_pkg::IDX_SELECT:  rdata_ff <= {24'h000000, select_ff};
                    spg_pkg::IDX_MODE:    rdata_ff <= {29'h00000000, mode_ff};
                    spg_pkg::IDX_STATUS:  rdata_ff <= {16'h0000, frame_ff, 6'h00, second_ff, busy_ff};
                    default:              rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rows_ff    <= spg_pkg::REG_RESET;
            cols_ff    <= spg_pkg::REG_RESET;
            integ_ff   <= spg_pkg::REG_RESET;
            period_ff  <= spg_pkg::REG_RESET[7:0];
            chans_ff   <= spg_pkg::REG_RESET[7:0];
            delay_ff   <= spg_pkg::REG_RESET[7:0];
            samples_ff <= spg_pkg::REG_RESET[7:0];
            select_ff  <= spg_pkg::REG_RESET[7:0];
            mode_ff    <= spg_pkg::MODE_RESET;
        end else if (wr_take) begin
            if (idx == spg_pkg::IDX_ROWS)  rows_ff  <= be_merge(rows_ff, wd16, be16);
            if (idx == spg_pkg::IDX_COLS)  cols_ff  <= be_merge(cols_ff, wd16, be16);
            if (idx == spg_pkg::IDX_INTEG) integ_ff <= be_merge(integ_ff, wd16, be16);
            if (wr_byte & (idx == spg_pkg::IDX_PERIOD))  period_ff  <= wd16[7:0];
            if (wr_byte & (idx == spg_pkg::IDX_CHANS))   chans_ff   <= wd16[7:0];
            if (wr_byte & (idx == spg_pkg::IDX_DELAY))   delay_ff   <= wd16[7:0];
            if (wr_byte & (idx == spg_pkg::IDX_SAMPLES)) samples_ff <= wd16[7:0];
            if (wr_byte & (idx == spg_pkg::IDX_SELECT))  select_ff  <= wd16[7:0];
            if (mode_wr) mode_ff <= wd16[2:0];
        end
    end

    // Pipeline priority pins: three-stage synchronisers, level taken when stages 2 and 3 agree, for the slot only while transfer stage 2 is high
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            xfer_sync_ff <= 3'h0;
            slot_s1_ff   <= 3'h0;
            slot_s2_ff   <= 3'h0;
            slot_s3_ff   <= 3'h0;
            xfer_lvl_ff  <= 1'b0;
            slot_lvl_ff  <= 3'h0;
        end else begin
            xfer_sync_ff <= {xfer_sync_ff[1:0], pipe_xfer_i};
            slot_s1_ff   <= pipe_slot_i;
            slot_s2_ff   <= slot_s1_ff;
            slot_s3_ff   <= slot_s2_ff;
            if (xfer_sync_ff[2] == xfer_sync_ff[1]) xfer_lvl_ff <= xfer_sync_ff[2];
            if (slot_s3_ff == slot_s2_ff & xfer_sync_ff[1]) slot_lvl_ff <= slot_s3_ff;
        end
    end

    // Tick divider and unit counter, restarted on each timed phase except the gap, which runs on from its burst
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div_ff  <= 32'h0;
            unit_ff <= 16'h0;
        end else if (load_tmr) begin
            div_ff  <= 32'h0;
            unit_ff <= 16'h0;
        end else begin
            div_ff  <= tick ? 32'h0 : div_ff + 32'h1;
            if (tick & (unit_ff != 16'hFFFF)) unit_ff <= unit_ff + 16'h1;
        end
    end

    // Sequence counters
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff  <= spg_pkg::S_IDLE;
            ch_ff     <= 8'h00;
            burst_ff  <= 32'h0;
            frame_ff  <= 8'h00;
            second_ff <= 1'b0;
            slot_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            ch_ff    <= (emitting & ~last_wd) ? ch_ff + 8'h01 : 8'h00;
            if (state_ff == spg_pkg::S_IDLE) begin
                burst_ff  <= 32'h0;
                frame_ff  <= 8'h00;
                second_ff <= 1'b0;
            end else if (state_ff == spg_pkg::S_DELAY) begin
                burst_ff <= 32'h0;
            end else if (state_ff == spg_pkg::S_BURST & last_wd) begin
                burst_ff <= burst_ff + 32'h1;
            end else if (state_ff == spg_pkg::S_INTEG & int_done) begin
                second_ff <= 1'b1;
                frame_ff  <= 8'h00;
            end
            if (frame_end & ~mode_wr) frame_ff <= frm_last ? 8'h00 : frame_ff + 8'h01;
            if (state_ff == spg_pkg::S_ARMED) slot_ff <= trig_slot;
            else if (state_ff == spg_pkg::S_SLOT & last_wd) slot_ff <= next_slot;
        end
    end

    // Pixel word and data content
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            valid_ff <= 1'b0;
            pix_ff   <= '0;
            seq_ff   <= 8'h00;
            lfsr_ff  <= spg_pkg::LFSR_SEED;
            xfer_ff  <= 1'b0;
            gslot_ff <= 3'h0;
            busy_ff  <= 1'b0;
        end else begin
            valid_ff <= emitting;
            xfer_ff  <= state_ff == spg_pkg::S_SLOT;
            gslot_ff <= (state_ff == spg_pkg::S_SLOT) ? slot_ff : 3'h0;
            busy_ff  <= (nxt_state != spg_pkg::S_IDLE) & (nxt_state != spg_pkg::S_ARMED);
            if (state_ff == spg_pkg::S_IDLE) begin
                seq_ff  <= 8'h00;
                lfsr_ff <= spg_pkg::LFSR_SEED;
            end else if (emitting) begin
                pix_ff.channel <= ch_ff;
                pix_ff.value   <= noise ? lfsr_ff : seq_ff;
                seq_ff         <= seq_ff + 8'h01;
                lfsr_ff        <= {1'b0, lfsr_ff[7:1]} ^ (lfsr_ff[0] ? spg_pkg::LFSR_TAPS : 8'h00);
            end
        end
    end

    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign pixel_valid_o     = valid_ff;
    assign pixel_o           = pix_ff;
    assign gen_xfer_o        = xfer_ff;
    assign gen_slot_o        = gslot_ff;
    assign busy_o            = busy_ff;

    // Helper counters for timing checks
    logic [31:0] gap_cyc_ff, run_cyc_ff;
    logic [7:0]  words_ff;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            gap_cyc_ff <= 32'h0;
            run_cyc_ff <= 32'h0;
            words_ff   <= 8'h00;
        end else begin
            gap_cyc_ff <= (nxt_state == spg_pkg::S_BURST & load_tmr) ? 32'h0 : gap_cyc_ff + 32'h1;
            run_cyc_ff <= (state_ff == spg_pkg::S_IDLE) ? 32'h0 : run_cyc_ff + 32'h1;
            words_ff   <= (nxt_state == spg_pkg::S_BURST & load_tmr) ? 8'h00 : words_ff + {7'h00, valid_ff};
        end
    end

    mode_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
        pixel_valid_o |-> $past(kind) != spg_pkg::KIND_OFF)
        else $error("pixel sent while generator disabled");
    seq_data_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (pixel_valid_o && $past(pixel_valid_o) && !$past(noise, 2) && !$past(mode_wr, 2))
        |-> pixel_o.value == $past(pixel_o.value) + 8'h01)
        else $error("sequential data did not increment");
    chan_id_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ($rose(pixel_valid_o) |-> pixel_o.channel == 8'h00) and
        ((pixel_valid_o && $past(pixel_valid_o) && pixel_o.channel != 8'h00)
         |-> pixel_o.channel == $past(pixel_o.channel) + 8'h01))
        else $error("channel id out of sequence");
    start_cmd_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_IDLE && nxt_state == spg_pkg::S_DELAY) |-> start_exposure_i)
        else $error("run began without start command");
    burst_gap_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_GAP && nxt_state == spg_pkg::S_BURST)
        |-> gap_cyc_ff >= {24'h0, period_ff} * spg_pkg::TICK_CYC)
        else $error("bursts spaced too closely");
    burst_late_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_GAP && nxt_state == spg_pkg::S_BURST
         && {24'h0, period_ff} * spg_pkg::TICK_CYC >= {24'h0, chans_ff})
        |-> gap_cyc_ff <= {24'h0, period_ff} * spg_pkg::TICK_CYC + 32'h1)
        else $error("bursts spaced too widely");
    burst_len_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_GAP && $past(state_ff) == spg_pkg::S_BURST && !$past(mode_wr))
        |-> words_ff + {7'h00, valid_ff} == chans_ff)
        else $error("burst length differs from channel count");
    first_delay_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_DELAY && nxt_state == spg_pkg::S_BURST && frame_ff == 8'h00 && !second_ff)
        |-> run_cyc_ff + 32'h1 >= {24'h0, delay_ff} * MS_CYC_P)
        else $error("first burst before start delay");
    integ_wait_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == spg_pkg::S_INTEG && nxt_state == spg_pkg::S_DELAY && !mode_wr)
        |=> second_ff && frame_ff == 8'h00)
        else $error("second readout not started after integration");
    slot_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        gen_xfer_o |-> gen_slot_o != 3'h0 && select_ff[gen_slot_o])
        else $error("transfer in unselected slot");
    vis_no_integ_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (kind != spg_pkg::KIND_IR) |=> state_ff != spg_pkg::S_INTEG || $past(mode_wr))
        else $error("integration wait outside infrared mode");
    slot_no_timer_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (kind == spg_pkg::KIND_SLOT) |=> (state_ff == spg_pkg::S_IDLE) || (state_ff == spg_pkg::S_ARMED)
        || (state_ff == spg_pkg::S_SLOT))
        else $error("timed phase entered in slot mode");

    vis_run_c: cover property (@(posedge clock_i) disable iff (reset_i)
        kind == spg_pkg::KIND_VIS && state_ff == spg_pkg::S_GAP && nxt_state == spg_pkg::S_IDLE);
    ir_integ_c: cover property (@(posedge clock_i) disable iff (reset_i)
        state_ff == spg_pkg::S_INTEG && nxt_state == spg_pkg::S_DELAY);
    burst_start_c: cover property (@(posedge clock_i) disable iff (reset_i)
        state_ff == spg_pkg::S_GAP && nxt_state == spg_pkg::S_BURST);
    slot_chain_c: cover property (@(posedge clock_i) disable iff (reset_i)
        state_ff == spg_pkg::S_SLOT && last_wd && chain_ok);
endmodule // spg_generator
`default_nettype wire

/* test/spg_host_model.sv */
// Far side model: pixel sink and other-board pipeline traffic
`timescale 1ns/10ps
`default_nettype none
module spg_host_model (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    input  wire logic                pixel_valid_i,
    input  wire spg_pkg::spg_pixel_t pixel_i,
    input  wire logic                board_go_i,
    input  wire logic [2:0]          board_slot_i,
    output logic                     pipe_xfer_o,
    output logic [2:0]               pipe_slot_o,
    output logic [15:0]              words_o,
    output logic                     order_err_o
);
    logic [7:0] chan_ff;
    logic [3:0] len_ff;
    // Released slot lines show the inverse, never a stale value
    assign pipe_xfer_o = (len_ff != 4'h0);
    assign pipe_slot_o = pipe_xfer_o ? board_slot_i : ~board_slot_i;
    // Channel id restarts at zero or steps by one
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            words_o <= 16'h0000;
            order_err_o <= 1'b0;
            chan_ff <= 8'h00;
        end else if (pixel_valid_i) begin
            words_o <= words_o + 16'h0001;
            chan_ff <= pixel_i.channel + 8'h01;
            if (pixel_i.channel !== 8'h00 && pixel_i.channel !== chan_ff) order_err_o <= 1'b1;
        end
    end
    // Board transfer of eight cycles in the commanded slot
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) len_ff <= 4'h0;
        else if (board_go_i) len_ff <= 4'h8;
        else if (len_ff != 4'h0) len_ff <= len_ff - 4'h1;
    end
endmodule // spg_host_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the synthetic pixel generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) check(n, 32'(e), 32'(a));
module tb_top;
    localparam int unsigned MS = 20;
    localparam logic [7:0] SEED = spg_pkg::LFSR_SEED;
    logic clock_i = 1'b0, reset_i = 1'b1, rd = 1'b0, wr = 1'b0, start = 1'b0, go = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h00000000, rdat, rq;
    logic [2:0] bslot = 3'h2, pslot, gslot;
    logic wait_o, pv, pxfer, gxfer, busy, oerr;
    logic [15:0] words, base;
    spg_pkg::spg_pixel_t px;
    int mismatches = 0, compares = 0;
    logic [2:0] modes [4] = '{3'h0, 3'h4, 3'h1, 3'h5};
    always #5 clock_i = ~clock_i;
    spg_generator #(.MS_CYC_P(MS)) DUT (.clock_i(clock_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .start_exposure_i(start),
        .pipe_xfer_i(pxfer), .pipe_slot_i(pslot), .pixel_valid_o(pv), .pixel_o(px),
        .gen_xfer_o(gxfer), .gen_slot_o(gslot), .busy_o(busy));
    spg_host_model far_end (.clock_i(clock_i), .reset_i(reset_i), .pixel_valid_i(pv), .pixel_i(px),
        .board_go_i(go), .board_slot_i(bslot), .pipe_xfer_o(pxfer), .pipe_slot_o(pslot),
        .words_o(words), .order_err_o(oerr));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] a);
        compares++;
        if (a !== e) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", n, e, a);
        end
    endtask
    // Avalon access held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [9:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        adr <= {idx, 2'h0};
        wdat <= {16'h0000, d};
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wait_o !== 1'b0 && n < 50);
        rq = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) `CHK("waitrequest", 0, 1)
    endtask
    // Start Exposure pulse, then count words, time the first one and check its value
    task automatic expose(input logic [15:0] n, input int lo, input logic [7:0] v);
        int c;
        c = 0;
        base = words;
        @(posedge clock_i);
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        while (pv !== 1'b1 && c < 3000) begin
            @(posedge clock_i);
            c++;
        end
        if (n != 16'h0000) `CHK("first delay", 1, (c >= lo - 2) && (c <= lo + 4))
        if (n != 16'h0000) `CHK("first value", v, px.value)
        repeat (1500) @(posedge clock_i);
        `CHK("run words", n, words - base)
        `CHK("idle after run", 0, busy)
        $display("test exposure done, %0d words", words - base);
    endtask
    // Another board transfers in slot s; count words that follow
    task automatic board(input logic [2:0] s, input logic [15:0] n);
        base = words;
        @(posedge clock_i);
        bslot <= s;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        repeat (40) @(posedge clock_i);
        `CHK("slot words", n, words - base)
        $display("test slot done, %0d words", words - base);
    endtask
    always @(negedge clock_i) if (gxfer === 1'b1) `CHK("filled slot", 3, gslot)
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: about two and a half times the expected run length
    initial begin
        repeat (60000) @(posedge clock_i);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        acc(1'b0, spg_pkg::IDX_MODE, 16'h0000);
        `CHK("mode reset", spg_pkg::MODE_RESET, rq)
        acc(1'b1, spg_pkg::IDX_ROWS, 16'hA5C3);
        acc(1'b0, spg_pkg::IDX_ROWS, 16'h0000);
        `CHK("row count", 16'hA5C3, rq)
        acc(1'b1, spg_pkg::IDX_PERIOD, 16'h1FF);
        acc(1'b0, spg_pkg::IDX_PERIOD, 16'h0000);
        `CHK("period width", 16'h00FF, rq)
        acc(1'b0, 10'h2E0, 16'h0000);
        `CHK("unmapped", 0, rq)
        $display("test registers done");
        acc(1'b1, spg_pkg::IDX_ROWS, 16'h0002);
        acc(1'b1, spg_pkg::IDX_COLS, 16'h0001);
        acc(1'b1, spg_pkg::IDX_PERIOD, 16'h0005);
        acc(1'b1, spg_pkg::IDX_CHANS, 16'h0003);
        acc(1'b1, spg_pkg::IDX_DELAY, 16'h0002);
        acc(1'b1, spg_pkg::IDX_SAMPLES, 16'h0002);
        acc(1'b1, spg_pkg::IDX_INTEG, 16'h0002);
        acc(1'b1, spg_pkg::IDX_SELECT, 16'h0008);
        // Off modes give nothing, visible modes one frame
        foreach (modes[i]) begin
            acc(1'b1, spg_pkg::IDX_MODE, {13'h0000, modes[i]});
            expose(modes[i][0] ? 16'h0006 : 16'h0000, 2 * MS, modes[i][2] ? SEED : 8'h00);
        end
        for (int m = 2; m <= 6; m += 4) begin
            acc(1'b1, spg_pkg::IDX_MODE, 16'(m));
            expose(16'h0018, 2 * MS, (m == 6) ? SEED : 8'h00);
        end
        for (int m = 3; m <= 7; m += 4) begin
            acc(1'b1, spg_pkg::IDX_MODE, 16'(m));
            expose(16'h0000, 0, 8'h00);
            board(3'h2, 16'h0003);
            board(3'h4, 16'h0000);
        end
        acc(1'b1, spg_pkg::IDX_SELECT, 16'h0001);
        board(3'h7, 16'h0000);
        `CHK("channel order", 0, oerr)
        summarize();
    end
endmodule // tb_top
`default_nettype wire
